//--- logic/gain_ctrl_pkg.sv
// Constants for the gain and mode serial control port.
// Assumes a 20 MHz system clock sampling the serial pins.
//
// Functional notes
// - Active-low select frames every transfer
// - MSB first, sampled on rising clock
// - Select rising edge copies word to latch
// - Eight bits: bit7 mode, bits6-0 gain
// - Mode 1 high power, 0 low noise
// - Latched gain code drives gain stage
// - All gain codes legal in both modes
// - Enable low disables path, keeps latch
// - Power-down low disables all, clears latch
package gain_ctrl_pkg;
  localparam int WORD_BITS = 8;
  localparam int GAIN_BITS = 7;
  localparam int MODE_BIT = 7;
  localparam int GAIN_MSB = 6;
  localparam int SYNC_STAGES = 3;
  localparam logic [7:0] WORD_RESET = 8'h00;
  localparam logic [3:0] BITS_RESET = 4'h0;
endpackage

//--- logic/gain_mode_serial_control.sv
// Serial control port with storage latch and path enables.
// Assumes select, serial clock and data are asynchronous pins
// sampled by clk, with the serial clock far slower than clk.
`timescale 1ns/1ps
`default_nettype none
module gain_mode_serial_control
(
  input wire logic clk,
  input wire logic reset,
  input wire logic select_n,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic signal_path_enable,
  input wire logic power_down_n,
  output logic high_power_mode,
  output logic low_noise_mode,
  output logic [6:0] gain_code,
  output logic programmable_gain_stage_on,
  output logic [7:0] gain_mode_control_word,
  output logic word_valid
);
  // Three-stage samplers; stage 0 is read only by stage 1
  logic [2:0] sel_sync;
  logic [2:0] sck_sync;
  logic [2:0] sda_sync;
  logic [2:0] en_sync;
  logic [2:0] pd_sync;
  logic sel_q;
  logic sck_q;
  logic next_sel_q;
  logic next_sck_q;
  logic [7:0] shift_word;
  logic [7:0] next_shift_word;
  logic [3:0] bit_count;
  logic [3:0] next_bit_count;
  logic [7:0] next_control_word;
  logic next_word_valid;
  logic sel_low;
  logic sck_rise;
  logic sel_rise;
  logic pd_active;

  // Filtered enable levels, so a glitch of one clk sample on a pin never toggles a stage
  logic en_q;
  logic pd_q;
  logic next_en_q;
  logic next_pd_q;

  // Next values of the registered stage controls
  logic next_high_power_mode;
  logic next_low_noise_mode;
  logic [6:0] next_gain_code;
  logic next_stage_on;

  // Filtered level: changes only when stages 1 and 2 agree
  function automatic logic agreed(input logic [2:0] s, input logic prev);
    agreed = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  // One output stage: both enables up and the mode bit as wanted
  function automatic logic stage_on(
    input logic en,
    input logic pd,
    input logic mode_bit,
    input logic want
  );
    stage_on = en && pd && (mode_bit == want);
  endfunction


  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sel_sync <= 3'h7;
      sck_sync <= 3'h0;
      sda_sync <= 3'h0;
      en_sync <= 3'h0;
      pd_sync <= 3'h0;
    end
    else
    begin
      sel_sync <= {sel_sync[1:0], select_n};
      sck_sync <= {sck_sync[1:0], serial_clock};
      sda_sync <= {sda_sync[1:0], serial_data};
      en_sync <= {en_sync[1:0], signal_path_enable};
      pd_sync <= {pd_sync[1:0], power_down_n};
    end
  end

  // Edge detection on the filtered select and clock levels
  always_comb
  begin
    next_sel_q = agreed(sel_sync, sel_q);
    next_sck_q = agreed(sck_sync, sck_q);
    sel_low = !next_sel_q;
    sck_rise = next_sck_q && !sck_q;
    sel_rise = next_sel_q && !sel_q;
    // Power-down also kills the serial port; uses the filtered level
    pd_active = !next_pd_q;
  end

  // Enable filters: a level counts once stages 1 and 2 agree
  always_comb
  begin
    next_en_q = agreed(en_sync, en_q);
    next_pd_q = agreed(pd_sync, pd_q);
  end

  // Both filters start low, so the path stays off until the pins settle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      en_q <= 1'b0;
      pd_q <= 1'b0;
    end
    else
    begin
      en_q <= next_en_q;
      pd_q <= next_pd_q;
    end
  end


  // Shift and latch next-state logic
  always_comb
  begin
    next_shift_word = shift_word;
    next_bit_count = bit_count;
    next_control_word = gain_mode_control_word;
    next_word_valid = word_valid;
    if (pd_active)
    begin
      next_shift_word = gain_ctrl_pkg::WORD_RESET;
      next_bit_count = gain_ctrl_pkg::BITS_RESET;
      next_control_word = gain_ctrl_pkg::WORD_RESET;
      next_word_valid = 1'b0;
    end
    else if (sel_rise)
    begin
      // latch on select rise
      // Only the last eight bits shifted count; extra leading bits fall off
      next_control_word = shift_word;
      next_word_valid = 1'b1;
      next_bit_count = gain_ctrl_pkg::BITS_RESET;
    end
    else if (sel_low && sck_rise)
    begin
      next_shift_word = {shift_word[6:0], sda_sync[2]};
      if (bit_count != 4'h8)
        next_bit_count = bit_count + 4'h1;
    end
    else if (!sel_low)
    begin
      next_bit_count = gain_ctrl_pkg::BITS_RESET;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sel_q <= 1'b1;
      sck_q <= 1'b0;
      shift_word <= gain_ctrl_pkg::WORD_RESET;
      bit_count <= gain_ctrl_pkg::BITS_RESET;
      gain_mode_control_word <= gain_ctrl_pkg::WORD_RESET;
      word_valid <= 1'b0;
    end
    else
    begin
      sel_q <= next_sel_q;
      sck_q <= next_sck_q;
      shift_word <= next_shift_word;
      bit_count <= next_bit_count;
      gain_mode_control_word <= next_control_word;
      word_valid <= next_word_valid;
    end
  end


  // Output controls from the latch and the filtered enables
  always_comb
  begin
    next_stage_on = en_q && pd_q;
    // bit 7 mode, bits 6-0 gain
    // mode 1 high power, 0 low noise
    next_high_power_mode = stage_on(en_q, pd_q,
      gain_mode_control_word[gain_ctrl_pkg::MODE_BIT], 1'b1);
    next_low_noise_mode = stage_on(en_q, pd_q,
      gain_mode_control_word[gain_ctrl_pkg::MODE_BIT], 1'b0);
    // every code passes in either mode
    // Gain is kept while the path is off, so re-enable needs no rewrite
    next_gain_code = gain_mode_control_word[gain_ctrl_pkg::GAIN_MSB:0];
  end

  // Registered outputs; one clock behind the latch
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      high_power_mode <= 1'b0;
      low_noise_mode <= 1'b0;
      gain_code <= 7'h00;
      programmable_gain_stage_on <= 1'b0;
    end
    else
    begin
      high_power_mode <= next_high_power_mode;
      low_noise_mode <= next_low_noise_mode;
      gain_code <= next_gain_code;
      programmable_gain_stage_on <= next_stage_on;
    end
  end
endmodule
`default_nettype wire

//--- testbench/gain_ctrl_host.sv
// Host model for the framed serial pins.
// Assumes the bench clk; pins idle between frames.
`timescale 1ns/1ps
`default_nettype none
module gain_ctrl_host
(
  input wire logic clk,
  output var logic select_n = 1'b1,
  output var logic serial_clock = 1'b0,
  output var logic serial_data = 1'b0
);
  task automatic send(input logic [7:0] w, input int h);
    @(posedge clk) select_n <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clk) serial_data <= w[i];
      repeat (h - 1) @(posedge clk);
      serial_clock <= 1'b1;
      repeat (h) @(posedge clk);
      serial_clock <= 1'b0;
    end
    repeat (h) @(posedge clk);
    select_n <= 1'b1;
    serial_data <= ~w[0]; // Released line shows no stale bit
  endtask
endmodule
`default_nettype wire

//--- testbench/gain_mode_serial_control_monitor.sv
// Checker for the serial gain control port.
// Sees only top ports; bound below.
`timescale 1ns/1ps
`default_nettype none
module gain_mode_serial_control_monitor
(
  input wire logic clk, reset, select_n, serial_clock, serial_data,
  input wire logic signal_path_enable, power_down_n, high_power_mode, low_noise_mode,
  input wire logic [6:0] gain_code,
  input wire logic programmable_gain_stage_on, word_valid,
  input wire logic [7:0] gain_mode_control_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Outputs tied to latch and pins; sync delay allowed
  AST_HP: assert property (high_power_mode |-> $past(gain_mode_control_word[7]))
    else $error("bad high power");
  AST_LN: assert property (low_noise_mode |-> !$past(gain_mode_control_word[7]))
    else $error("bad low noise");
  AST_EX: assert property (!(high_power_mode && low_noise_mode))
    else $error("both modes");
  AST_GN: assert property (gain_code == $past(gain_mode_control_word[6:0]))
    else $error("bad gain");
  AST_PD: assert property (!power_down_n [*6] |->
    gain_mode_control_word == 8'h00 && !word_valid && !programmable_gain_stage_on)
    else $error("latch kept");
  AST_OF: assert property (!signal_path_enable [*6] |->
    !(high_power_mode || low_noise_mode || programmable_gain_stage_on))
    else $error("path on");
  AST_ON: assert property ((signal_path_enable && power_down_n) [*6] |->
    programmable_gain_stage_on)
    else $error("path off");
  AST_HOLD: assert property ((select_n && power_down_n) [*8] |->
    $stable(gain_mode_control_word))
    else $error("latch moved");
  cover property ($rose(high_power_mode));
  cover property ($rose(low_noise_mode));
  cover property ($fell(word_valid));
endmodule
bind gain_mode_serial_control gain_mode_serial_control_monitor i_mon (.*);
`default_nettype wire

//--- testbench/gain_mode_serial_control_tb.sv
// Bench for the serial gain control port.
// Host model drives serial pins; bench drives enables.
`timescale 1ns/1ps
`default_nettype none
module gain_mode_serial_control_tb;
  logic clk = 1'b0, reset = 1'b1, signal_path_enable = 1'b1, power_down_n = 1'b1;
  logic select_n, serial_clock, serial_data, high_power_mode, low_noise_mode;
  logic programmable_gain_stage_on, word_valid;
  logic [6:0] gain_code;
  logic [7:0] gain_mode_control_word;
  logic [7:0] words [5] = '{8'hFF, 8'h80, 8'h7F, 8'h00, 8'hD6};
  int error_cnt = 0, checked = 0;
  gain_mode_serial_control i_gain_mode_serial_control (.*);
  gain_ctrl_host i_gain_ctrl_host (.*);
  always #25 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Frame then settle past the sync delay
  task automatic put(input logic [7:0] w, input int h);
    i_gain_ctrl_host.send(w, h);
    repeat (10) @(posedge clk);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
    foreach (words[i])
    begin
      put(words[i], 4);
      chk(gain_mode_control_word, words[i]);
      chk({high_power_mode, gain_code}, words[i]);
      chk({5'h00, low_noise_mode, word_valid, programmable_gain_stage_on},
        {5'h00, ~words[i][7], 2'b11});
    end
    signal_path_enable <= 1'b0;
    repeat (8) @(posedge clk);
    chk({high_power_mode, low_noise_mode, programmable_gain_stage_on, 5'h00}, 8'h00);
    chk({1'b0, gain_code}, {1'b0, words[4][6:0]});
    signal_path_enable <= 1'b1;
    power_down_n <= 1'b0;
    put(8'hAA, 4);
    chk({word_valid, gain_mode_control_word[6:0]}, 8'h00);
    power_down_n <= 1'b1;
    repeat (5) @(posedge clk);
    put(8'hC3, 4);
    chk(gain_mode_control_word, 8'hC3);
    finish_test;
  end
  // Hang guard, well past the expected run
  initial
  begin
    #200000;
    error_cnt++;
    finish_test;
  end
endmodule
`default_nettype wire
